// ==== drive_run_stop_sequencer_test.sv ====
`timescale 1ns/10ps
module drive_run_stop_sequencer_test;
  import drs_pkg::*;
  localparam int HOLD = 20;
  localparam int L = 4;
  logic clk_sys_in = 0, sys_rst_in = 1;
  logic run = 0, en = 0, inch = 0, pstp = 1, cst = 1, trip = 0, trst = 0;
  logic t_on = 0, t_off = 0, t_cpl = 0, f_int = 1, regen = 1, isel = 0;
  logic crev = 0, spin = 0;
  logic signed [15:0] setp = 16'sh0640, in1 = 16'sh0100, in2 = -16'sh0200;
  logic [14:0] crawl = 15'h0080, nstep = 15'h0040, estep = 15'h0020;
  logic [14:0] cap = 15'h0032;
  logic [31:0] nper = 32'h0000003C, eper = 32'h0000003C;
  logic [7:0] kp = 8'h10, ki = 8'h00;
  logic [15:0] rspd = 16'h2710, zb = 16'h0004, rfld = 16'h03E8;
  logic signed [15:0] fbk, ref_o, dem;
  logic [15:0] fcur;
  logic con, stk, qch, rn, lko, ton, tdn, tab, ter;
  int error_cnt = 0, n_compared = 0;

  drs_sequencer #(.HOLDOFF_CYCLES(32'd20), .TUNE_TIMEOUT(32'd200)) i_dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .run_input_in(run), .enable_input_in(en), .inch_mode_input_in(inch),
    .ramp_stop_input_in(pstp), .freewheel_stop_input_in(cst),
    .trip_in(trip), .trip_reset_in(trst), .autotune_on_in(t_on),
    .autotune_off_in(t_off), .tune_complete_in(t_cpl),
    .field_internal_in(f_int), .regen_in(regen), .inch_select_in(isel),
    .crawl_reverse_in(crev), .setpoint_in(setp), .inch_speed_1_in(in1),
    .inch_speed_2_in(in2), .crawl_speed_in(crawl),
    .normal_ramp_step_in(nstep), .emergency_ramp_step_in(estep),
    .normal_stop_period_in(nper), .emergency_ramp_period_in(eper),
    .emergency_ramp_current_cap_in(cap), .proportional_factor_in(kp),
    .integral_factor_in(ki), .speed_fbk_in(fbk), .rated_speed_in(rspd),
    .zero_band_in(zb), .field_current_in(fcur), .rated_field_in(rfld),
    .contactor_out(con), .stack_enable_out(stk), .field_quench_out(qch),
    .running_out(rn), .trip_lockout_out(lko), .autotune_on_out(ton),
    .tune_done_out(tdn), .tune_aborted_out(tab), .tune_error_out(ter),
    .speed_ref_out(ref_o), .current_demand_out(dem));

  drs_motor_model i_motor (
    .clk_sys_in(clk_sys_in), .contactor_in(con), .stack_enable_in(stk),
    .field_quench_in(qch), .current_demand_in(dem), .spin_in(spin),
    .rated_field_in(rfld), .speed_fbk_out(fbk), .field_current_out(fcur));

  initial forever #50 clk_sys_in = ~clk_sys_in;

  // inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic pins(input logic r, e, j, p, c);
    run = r;
    en = e;
    inch = j;
    pstp = p;
    cst = c;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_con(input logic v, input int n);
    for (int i = 0; i < n && con !== v; i++) cyc(1);
    chk_bit(con, v);
  endtask

  // request, then run, then enable closes contactor
  task automatic tune_go;
    t_on = 1;
    cyc(1);
    t_on = 0;
    cyc(2);
    pins(1, 0, 0, 1, 1);
    cyc(2);
    pins(1, 1, 0, 1, 1);
    cyc(L);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // whole run is at most about 1160 cycles
  initial begin
    repeat (6000) @(posedge clk_sys_in);
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    conclude();
  end

  initial begin
    cyc(16);
    chk_bit(con, 1'b0);
    chk_bit(stk, 1'b0);
    chk_word(ref_o, 16'h0000);
    sys_rst_in = 0;
    done("reset");
    pins(1, 1, 0, 0, 1); cyc(8); chk_bit(con, 1'b0);
    pins(1, 1, 0, 1, 0); cyc(8); chk_bit(con, 1'b0);
    trip = 1; pins(1, 1, 0, 1, 1); cyc(8); chk_bit(con, 1'b0);
    chk_bit(lko, 1'b1);
    trip = 0; pins(0, 0, 0, 1, 1); trst = 1; cyc(1); trst = 0; cyc(L);
    chk_bit(lko, 1'b0);
    done("refusal");
    pins(0, 1, 0, 1, 1); cyc(2); pins(1, 1, 0, 1, 1); cyc(L);
    chk_bit(con, 1'b1);
    chk_bit(stk, 1'b1);
    chk_word(ref_o, setp);
    cyc(100); pins(0, 1, 0, 1, 1); cyc(L);
    chk_bit(rn, 1'b0);
    cyc(4); chk_bit(con, 1'b1);
    chk_bit(ref_o < setp, 1'b1);
    wait_con(1'b0, 70);
    done("normal stop");
    pins(1, 0, 0, 1, 1); cyc(8); chk_bit(con, 1'b0);
    pins(1, 1, 0, 1, 1); cyc(L); chk_bit(con, 1'b1);
    cyc(60); eper = 32'h0000001E; pins(1, 1, 0, 0, 1); cyc(L);
    chk_bit(rn, 1'b0);
    for (int i = 0; i < 10; i++) begin
      chk_bit(int'(dem) <= int'(cap) && int'(dem) >= -int'(cap), 1'b1);
      cyc(1);
    end
    wait_con(1'b0, 40);
    pins(0, 1, 0, 1, 1); cyc(4);
    done("program stop");
    pins(1, 1, 0, 1, 1); cyc(L + 40); chk_bit(con, 1'b1);
    pins(1, 1, 0, 0, 0); cyc(L); chk_bit(con, 1'b0);
    chk_bit(stk, 1'b0);
    pins(0, 1, 0, 1, 1); cyc(4);
    done("coast");
    pins(1, 1, 0, 1, 1); cyc(L); trip = 1; cyc(L);
    chk_bit(con, 1'b0);
    chk_bit(lko, 1'b1);
    trip = 0; cyc(L); chk_bit(stk, 1'b0);
    trst = 1; cyc(1); trst = 0; cyc(L); chk_bit(lko, 1'b0);
    pins(0, 1, 0, 1, 1); wait_con(1'b0, 70);
    done("trip");
    regen = 0; pins(1, 1, 0, 1, 1); cyc(L + 60); pins(0, 1, 0, 1, 1);
    wait_con(1'b0, 40);
    regen = 1;
    done("non-regen");
    pins(0, 1, 1, 1, 1); cyc(L); chk_bit(rn, 1'b1);
    chk_word(ref_o, in1);
    pins(0, 1, 0, 1, 1); cyc(L); chk_bit(con, 1'b1);
    chk_bit(stk, 1'b0);
    isel = 1; pins(0, 1, 1, 1, 1); cyc(L); chk_bit(stk, 1'b1);
    chk_word(ref_o, in2);
    pins(0, 1, 0, 1, 1); cyc(HOLD - 8); chk_bit(con, 1'b1);
    wait_con(1'b0, 14);
    isel = 0;
    done("jog");
    for (int d = 0; d < 2; d++) begin
      crev = d[0]; pins(1, 0, 1, 1, 1); cyc(L);
      chk_bit(rn, 1'b1);
      chk_word(ref_o, d ? -$signed({1'b0, crawl}) : {1'b0, crawl});
      pins(0, 0, 0, 1, 1); wait_con(1'b0, HOLD + 10);
    end
    crev = 0;
    done("crawl");
    setp = 16'sh0000; cyc(4);
    tune_go(); chk_bit(ton, 1'b1);
    chk_bit(con, 1'b1);
    chk_bit(qch, 1'b1);
    // run is still held, so idle may start a plain run right after the end
    t_cpl = 1; cyc(1); t_cpl = 0;
    chk_bit(tdn, 1'b1);
    chk_bit(ton, 1'b0);
    chk_bit(con, 1'b0);
    pins(0, 0, 0, 1, 1); cyc(4); wait_con(1'b0, 70);
    f_int = 0; tune_go(); cyc(4); chk_bit(ter, 1'b1);
    chk_bit(tdn, 1'b0);
    chk_bit(con, 1'b0);
    f_int = 1; pins(0, 0, 0, 1, 1); cyc(4);
    tune_go(); chk_bit(ter, 1'b0);
    spin = 1; cyc(L); chk_bit(ter, 1'b1);
    chk_bit(con, 1'b0);
    spin = 0; pins(0, 0, 0, 1, 1); cyc(40);
    tune_go(); chk_bit(con, 1'b1);
    t_off = 1; cyc(1); t_off = 0; cyc(1); chk_bit(tab, 1'b1);
    chk_bit(con, 1'b0);
    pins(0, 0, 0, 1, 1); cyc(4); wait_con(1'b0, 70);
    tune_go(); cyc(180); chk_bit(tab, 1'b0);
    // the abort edge itself: a held run and request would restart the tune
    cyc(19); chk_bit(tab, 1'b1);
    chk_bit(con, 1'b0);
    pins(0, 0, 0, 1, 1); cyc(4);
    done("autotune");
    conclude();
  end
endmodule // drive_run_stop_sequencer_test

// ==== drs_motor_model.sv ====
`timescale 1ns/10ps
// far side: contactor, armature and field of the motor
module drs_motor_model (
  input wire logic clk_sys_in,
  input wire logic contactor_in,
  input wire logic stack_enable_in,
  input wire logic field_quench_in,
  input wire logic signed [15:0] current_demand_in,
  input wire logic spin_in,
  input wire logic [15:0] rated_field_in,
  output logic signed [15:0] speed_fbk_out,
  output logic [15:0] field_current_out
);
  initial speed_fbk_out = '0;
  // spin_in is a shaft driven by the load, only when a test asks for it
  always @(posedge clk_sys_in) begin
    if (spin_in)
      speed_fbk_out <= 16'sh0BB8;
    else if (contactor_in && stack_enable_in)
      speed_fbk_out <= speed_fbk_out + (current_demand_in >>> 2);
    else
      speed_fbk_out <= speed_fbk_out - (speed_fbk_out >>> 3);
  end
  // no third-party field: full field unless the device quenches it
  assign field_current_out = field_quench_in ? 16'h0000 : rated_field_in;
endmodule // drs_motor_model

// ==== drs_pkg.sv ====
package drs_pkg;
  // widths
  localparam int W_DATA = 16;
  localparam int W_TMR = 32;
  localparam int W_ACC = 32;
  localparam int W_GAIN = 8;

  // clock and times
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned HOLDOFF_MS = 1000;
  localparam int unsigned HOLDOFF_CYCLES_DEF = HOLDOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned TUNE_TIMEOUT_S = 120;
  localparam int unsigned TUNE_TIMEOUT_DEF = TUNE_TIMEOUT_S * CLK_HZ;

  // autotune supervision thresholds, percent of rated
  localparam logic [31:0] PCT_FULL = 32'h0000_0064;
  localparam logic [31:0] PCT_SPEED = 32'h0000_0014;
  localparam logic [31:0] PCT_FIELD = 32'h0000_0006;

  // speed controller output scaling
  localparam int PI_SHIFT = 8;
  localparam logic signed [W_ACC-1:0] SAT_HI = 32'sh0000_7FFF;
  localparam logic signed [W_ACC-1:0] SAT_LO = -32'sh0000_8000;

  // synchroniser bit positions
  localparam int IN_RUN = 0;
  localparam int IN_EN = 1;
  localparam int IN_INCH = 2;
  localparam int IN_RAMP = 3;
  localparam int IN_FREE = 4;
  localparam int IN_TRIP = 5;
  localparam int IN_RST = 6;
  localparam int N_SYNC = 7;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RUN = 8'h02,
    ST_JOG = 8'h04,
    ST_HOLD = 8'h08,
    ST_NSTOP = 8'h10,
    ST_PSTOP = 8'h20,
    ST_TUNE = 8'h40,
    ST_TRIP = 8'h80
  } drs_state_t;

  typedef struct packed {
    drs_state_t state;
    logic [N_SYNC-1:0] s1;
    logic [N_SYNC-1:0] s2;
    logic rst_prev;
    logic tune_req;
    logic [W_TMR-1:0] tmr;
    logic signed [W_DATA-1:0] sref;
    logic signed [W_ACC-1:0] integ;
    logic signed [W_DATA-1:0] demand;
    logic contactor;
    logic stack_en;
    logic quench;
    logic done;
    logic aborted;
    logic error;
    logic lockout;
    logic running;
  } drs_reg_t;
endpackage

// ==== drs_sequencer.sv ====
`timescale 1ns/10ps
// Functional notes
// - tune starts on request, run, enable
// - tune complete opens contactor, clears request
// - lost precondition other than enable, or timeout, aborts tune
// - overspeed or field current errors tune
// - internal field quenched during tune
// - coast beats program stop beats normal
// - run removal ramps speed to zero
// - program stop ramps with current cap
// - stop timers force coast on expiry
// - coast quenches stack, opens contactor
// - coast gates run relay directly
// - trip coasts, locks until cleared and reset
// - no start on alarm or low stops
// - enable plus inch runs inch speed
// - run plus inch runs crawl speed
// - hold-off stops contactor chatter on jogs
// - non-regen stops coast on demand reversal
// - pi controller, zero integral factor disables the integral term
module drs_sequencer #(
  parameter logic [31:0] HOLDOFF_CYCLES = 32'(drs_pkg::HOLDOFF_CYCLES_DEF),
  parameter logic [31:0] TUNE_TIMEOUT = 32'(drs_pkg::TUNE_TIMEOUT_DEF)
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic run_input_in,
  input wire logic enable_input_in,
  input wire logic inch_mode_input_in,
  input wire logic ramp_stop_input_in,
  input wire logic freewheel_stop_input_in,
  input wire logic trip_in,
  input wire logic trip_reset_in,
  input wire logic autotune_on_in,
  input wire logic autotune_off_in,
  input wire logic tune_complete_in,
  input wire logic field_internal_in,
  input wire logic regen_in,
  input wire logic inch_select_in,
  input wire logic crawl_reverse_in,
  input wire logic signed [drs_pkg::W_DATA-1:0] setpoint_in,
  input wire logic signed [drs_pkg::W_DATA-1:0] inch_speed_1_in,
  input wire logic signed [drs_pkg::W_DATA-1:0] inch_speed_2_in,
  input wire logic [drs_pkg::W_DATA-2:0] crawl_speed_in,
  input wire logic [drs_pkg::W_DATA-2:0] normal_ramp_step_in,
  input wire logic [drs_pkg::W_DATA-2:0] emergency_ramp_step_in,
  input wire logic [drs_pkg::W_TMR-1:0] normal_stop_period_in,
  input wire logic [drs_pkg::W_TMR-1:0] emergency_ramp_period_in,
  input wire logic [drs_pkg::W_DATA-2:0] emergency_ramp_current_cap_in,
  input wire logic [drs_pkg::W_GAIN-1:0] proportional_factor_in,
  input wire logic [drs_pkg::W_GAIN-1:0] integral_factor_in,
  input wire logic signed [drs_pkg::W_DATA-1:0] speed_fbk_in,
  input wire logic [drs_pkg::W_DATA-1:0] rated_speed_in,
  input wire logic [drs_pkg::W_DATA-1:0] zero_band_in,
  input wire logic [drs_pkg::W_DATA-1:0] field_current_in,
  input wire logic [drs_pkg::W_DATA-1:0] rated_field_in,
  output logic contactor_out,
  output logic stack_enable_out,
  output logic field_quench_out,
  output logic running_out,
  output logic trip_lockout_out,
  output logic autotune_on_out,
  output logic tune_done_out,
  output logic tune_aborted_out,
  output logic tune_error_out,
  output logic signed [drs_pkg::W_DATA-1:0] speed_ref_out,
  output logic signed [drs_pkg::W_DATA-1:0] current_demand_out
);
  import drs_pkg::*;

  localparam drs_reg_t R_INIT = '{state: ST_IDLE, default: '0};

  drs_reg_t r;
  drs_reg_t n;

  logic run_s;
  logic en_s;
  logic inch_s;
  logic ramp_s;
  logic free_s;
  logic alarm_s;
  logic rst_rise;
  logic start_ok;
  logic jog_req;
  logic signed [W_DATA:0] err;
  logic signed [W_DATA+W_GAIN+1:0] p_term;
  logic signed [W_DATA+W_GAIN+1:0] i_step;
  logic signed [W_ACC-1:0] integ_n;
  logic signed [W_ACC-1:0] pi_scaled;
  logic signed [W_DATA-1:0] pi_sat;
  logic signed [W_DATA-1:0] cap_pos;
  logic signed [W_DATA-1:0] demand_n;
  logic [W_DATA:0] fbk_mag;
  logic at_zero;
  logic over_speed;
  logic over_field;
  logic reversed;
  logic tune_lost;
  logic nstop_expired;
  logic pstop_expired;

  // only the second stage is read; the first may be metastable
  assign run_s = r.s2[IN_RUN];
  assign en_s = r.s2[IN_EN];
  assign inch_s = r.s2[IN_INCH];
  assign ramp_s = r.s2[IN_RAMP];
  assign free_s = r.s2[IN_FREE];
  assign alarm_s = r.s2[IN_TRIP];
  assign rst_rise = r.s2[IN_RST] & ~r.rst_prev;

  assign start_ok = ~alarm_s & ramp_s & free_s;
  assign jog_req = inch_s & (en_s | run_s);

  // speed controller
  assign err = {r.sref[W_DATA-1], r.sref} - {speed_fbk_in[W_DATA-1],
    speed_fbk_in};
  assign p_term = err * $signed({1'b0, proportional_factor_in});
  assign i_step = err * $signed({1'b0, integral_factor_in});
  assign integ_n = (integral_factor_in == '0) ? '0 :
    r.integ + {{(W_ACC-W_DATA-W_GAIN-2){i_step[W_DATA+W_GAIN+1]}},
    i_step};
  // cast signed so the scaling shift keeps the sign of a braking demand
  assign pi_scaled = $signed({{(W_ACC-W_DATA-W_GAIN-2){
    p_term[W_DATA+W_GAIN+1]}}, p_term} + integ_n) >>> PI_SHIFT;
  assign pi_sat = (pi_scaled > SAT_HI) ? W_DATA'(SAT_HI) :
    (pi_scaled < SAT_LO) ? W_DATA'(SAT_LO) : W_DATA'(pi_scaled);
  assign cap_pos = $signed({1'b0, emergency_ramp_current_cap_in});

  // program stop limits current to the cap in both directions
  always_comb begin
    demand_n = pi_sat;
    if (r.state == ST_PSTOP) begin
      if (pi_sat > cap_pos) begin
        demand_n = cap_pos;
      end else if (pi_sat < -cap_pos) begin
        demand_n = -cap_pos;
      end
    end
  end

  // supervision
  assign fbk_mag = speed_fbk_in[W_DATA-1] ?
    -{speed_fbk_in[W_DATA-1], speed_fbk_in} :
    {speed_fbk_in[W_DATA-1], speed_fbk_in};
  assign at_zero = fbk_mag <= {1'b0, zero_band_in};
  assign over_speed = ({15'h0000, fbk_mag} * PCT_FULL) >
    ({16'h0000, rated_speed_in} * PCT_SPEED);
  assign over_field = ({16'h0000, field_current_in} * PCT_FULL) >
    ({16'h0000, rated_field_in} * PCT_FIELD);
  // demand opposing motion means a two-quadrant bridge has lost control
  assign reversed = (r.demand != '0) && !at_zero &&
    (r.demand[W_DATA-1] != speed_fbk_in[W_DATA-1]);
  assign tune_lost = ~r.tune_req | ~run_s | ~ramp_s | ~free_s |
    alarm_s | (r.tmr >= TUNE_TIMEOUT - 32'h1);
  assign nstop_expired = r.tmr >= normal_stop_period_in;
  assign pstop_expired = r.tmr >= emergency_ramp_period_in;

  function automatic logic signed [W_DATA-1:0] drs_to_zero(
    input logic signed [W_DATA-1:0] v,
    input logic [W_DATA-2:0] step
  );
    logic signed [W_DATA:0] s;
    logic signed [W_DATA:0] w;
    s = $signed({2'b00, step});
    w = {v[W_DATA-1], v};
    if (w > s) begin
      drs_to_zero = W_DATA'(w - s);
    end else if (w < -s) begin
      drs_to_zero = W_DATA'(w + s);
    end else begin
      drs_to_zero = '0;
    end
  endfunction

  always_comb begin
    n = r;
    n.s1 = {trip_reset_in, trip_in, freewheel_stop_input_in,
      ramp_stop_input_in, inch_mode_input_in, enable_input_in,
      run_input_in};
    n.s2 = r.s1;
    n.rst_prev = r.s2[IN_RST];
    // a new request wins over the end-of-tune clear
    if (autotune_on_in) begin
      n.tune_req = 1'b1;
    end else if (autotune_off_in) begin
      n.tune_req = 1'b0;
    end
    case (r.state)
      ST_IDLE: begin
        n.sref = '0;
        if (alarm_s) begin
          n.state = ST_TRIP;
        end else if (start_ok && r.tune_req && run_s && en_s) begin
          n.state = ST_TUNE;
          n.done = 1'b0;
          n.aborted = 1'b0;
          n.error = 1'b0;
        end else if (start_ok && jog_req) begin
          n.state = ST_JOG;
        end else if (start_ok && run_s && en_s) begin
          n.state = ST_RUN;
        end
      end
      ST_RUN: begin
        n.sref = setpoint_in;
        if (alarm_s) begin
          n.state = ST_TRIP;
        end else if (!free_s) begin
          n.state = ST_IDLE;
        end else if (!ramp_s) begin
          n.state = ST_PSTOP;
        end else if (!run_s) begin
          n.state = ST_NSTOP;
        end
      end
      ST_JOG: begin
        if (run_s) begin
          n.sref = crawl_reverse_in ? -$signed({1'b0, crawl_speed_in}) :
            $signed({1'b0, crawl_speed_in});
        end else begin
          n.sref = inch_select_in ? inch_speed_2_in : inch_speed_1_in;
        end
        if (alarm_s) begin
          n.state = ST_TRIP;
        end else if (!free_s) begin
          n.state = ST_IDLE;
        end else if (!ramp_s) begin
          n.state = ST_PSTOP;
        end else if (!jog_req) begin
          n.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        n.sref = '0;
        if (alarm_s) begin
          n.state = ST_TRIP;
        end else if (!free_s) begin
          n.state = ST_IDLE;
        end else if (jog_req && ramp_s) begin
          n.state = ST_JOG;
        end else if (r.tmr >= HOLDOFF_CYCLES - 32'h1) begin
          n.state = ST_IDLE;
        end
      end
      ST_NSTOP: begin
        n.sref = drs_to_zero(r.sref, normal_ramp_step_in);
        if (alarm_s) begin
          n.state = ST_TRIP;
        end else if (!free_s) begin
          n.state = ST_IDLE;
        end else if (!ramp_s) begin
          n.state = ST_PSTOP;
        end else if (nstop_expired || at_zero) begin
          n.state = ST_IDLE;
        end else if (!regen_in && reversed) begin
          n.state = ST_IDLE;
        end
      end
      ST_PSTOP: begin
        n.sref = drs_to_zero(r.sref, emergency_ramp_step_in);
        if (alarm_s) begin
          n.state = ST_TRIP;
        end else if (!free_s) begin
          n.state = ST_IDLE;
        end else if (pstop_expired || at_zero) begin
          n.state = ST_IDLE;
        end else if (!regen_in && reversed) begin
          n.state = ST_IDLE;
        end
      end
      ST_TUNE: begin
        n.sref = '0;
        if (tune_lost) begin
          n.state = alarm_s ? ST_TRIP : ST_IDLE;
          n.aborted = 1'b1;
        end else if (over_speed || over_field) begin
          n.state = ST_IDLE;
          n.error = 1'b1;
        end else if (tune_complete_in) begin
          n.state = ST_IDLE;
          n.done = 1'b1;
          if (!autotune_on_in) begin
            n.tune_req = 1'b0;
          end
        end
      end
      ST_TRIP: begin
        n.sref = '0;
        if (!alarm_s && rst_rise) begin
          n.state = ST_IDLE;
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
    n.tmr = (n.state != r.state) ? '0 : r.tmr + 32'h1;
    // the coast level gates the relay last, past every state decision
    n.contactor = free_s && (n.state inside {ST_RUN, ST_JOG, ST_HOLD,
      ST_NSTOP, ST_PSTOP, ST_TUNE});
    n.stack_en = free_s && en_s && (n.state inside {ST_RUN, ST_JOG,
      ST_NSTOP, ST_PSTOP, ST_TUNE});
    n.quench = (n.state == ST_TUNE) && field_internal_in;
    n.lockout = n.state == ST_TRIP;
    n.running = n.state inside {ST_RUN, ST_JOG};
    n.integ = n.stack_en ? integ_n : '0;
    n.demand = n.stack_en ? demand_n : '0;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      r <= R_INIT;
    end else begin
      r <= n;
    end
  end

  assign contactor_out = r.contactor;
  assign stack_enable_out = r.stack_en;
  assign field_quench_out = r.quench;
  assign running_out = r.running;
  assign trip_lockout_out = r.lockout;
  assign autotune_on_out = r.tune_req;
  assign tune_done_out = r.done;
  assign tune_aborted_out = r.aborted;
  assign tune_error_out = r.error;
  assign speed_ref_out = r.sref;
  assign current_demand_out = r.demand;

  a_coast_drops_relay: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !free_s |=> !contactor_out && !stack_enable_out)
    else $error("coast input low but relay or stack still on");

  a_trip_holds_lock: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (r.state == ST_TRIP && alarm_s) |=> trip_lockout_out && !stack_enable_out)
    else $error("stack released while trip is still present");

  a_start_refused: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (r.state == ST_IDLE && !start_ok) |=> !running_out && !contactor_out)
    else $error("started with alarm or low stop input");

  a_tune_done_clear: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    $rose(tune_done_out) && !$past(autotune_on_in)
    |-> !autotune_on_out && !contactor_out)
    else $error("tune end left request or contactor on");

  a_tune_abort_drop: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (r.state == ST_TUNE && !ramp_s) |=> tune_aborted_out && !contactor_out)
    else $error("lost tune precondition did not abort");

  a_tune_error_flag: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (r.state == ST_TUNE && !tune_lost && over_speed)
    |=> tune_error_out && !contactor_out)
    else $error("overspeed during tune not reported");

  a_field_quenched: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (r.state == ST_TUNE) && $past(field_internal_in) |-> field_quench_out)
    else $error("internal field not quenched during tune");

  a_nstop_timeout: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (r.state == ST_NSTOP && nstop_expired) |=> r.state != ST_NSTOP)
    else $error("normal stop outlived its period");

  a_pstop_cap: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    $past(r.state == ST_PSTOP) |-> current_demand_out <=
    $signed({1'b0, $past(emergency_ramp_current_cap_in)}))
    else $error("program stop current above cap");

  a_holdoff_keeps: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (r.state == ST_HOLD) |-> contactor_out)
    else $error("contactor dropped during hold-off");

  a_zero_integral: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    integral_factor_in == '0 |=> r.integ == '0)
    else $error("integral term active with zero factor");
endmodule // drs_sequencer
